// ### swr_params.svh
// constants for the supply watchdog reset sequencer
// assumes a 100 MHz mclk_i; the time base tick is derived from it
//
// Contract
// - supply low drives both reset outputs low in the same cycle
// - hold both low while supply low; release primary 50 ms, secondary 60 ms after
// - no kick activity for a full selected period asserts both resets
// - after watchdog reset primary low 50 ms, secondary a further 10 ms
// - watchdog count restarts when primary reset returns high
// - select pins pick 0.75, 1.5, 12.5 or 25 ms period
// - realised period within 0.4-1.28 ms shortest, at most 38 ms longest
// - every rising or falling kick edge restarts the watchdog count
// - floating or mid-supply kick input disables the watchdog; the code disables it only from the separate watchdog_disable_i pin
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH
`define SWR_CLK_HZ 100000000
// time base tick period in microseconds
`define SWR_TICK_US 50
`define SWR_TICK_CYC ((`SWR_CLK_HZ / 1000000) * `SWR_TICK_US)
// times in microseconds
`define SWR_T1_US 50000
`define SWR_T2_US 10000
`define SWR_WD0_US 750
`define SWR_WD1_US 1500
`define SWR_WD2_US 12500
`define SWR_WD3_US 25000
`define SWR_T1_TICKS (`SWR_T1_US / `SWR_TICK_US)
`define SWR_T2_TICKS (`SWR_T2_US / `SWR_TICK_US)
`define SWR_WD0_TICKS (`SWR_WD0_US / `SWR_TICK_US)
`define SWR_WD1_TICKS (`SWR_WD1_US / `SWR_TICK_US)
`define SWR_WD2_TICKS (`SWR_WD2_US / `SWR_TICK_US)
`define SWR_WD3_TICKS (`SWR_WD3_US / `SWR_TICK_US)
`define SWR_CNT_W 16
// synchroniser bit positions of the pin inputs
`define SWR_PIN_N 5
`define SWR_PIN_SUP 4
`define SWR_PIN_KICK 3
`define SWR_PIN_DIS 2
`define SWR_PIN_SEL_HI 1
`define SWR_PIN_SEL_LO 0
`endif

// ### swr_tick.sv
// time base divider: one-cycle tick every TICK_CYC enabled cycles
// assumes a single clock domain
`timescale 1ns/1ns
`default_nettype none
`include "swr_params.svh"
module swr_tick #(
   parameter int TICK_CYC = `SWR_TICK_CYC
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   output logic tick_o
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;

   always_comb begin
      if (cnt_reg == 16'(TICK_CYC - 1)) begin
         cnt_next = 16'h0000;
      end else begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 16'h0000;
      end else if (ce_i) begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick_o = ce_i && (cnt_reg == 16'(TICK_CYC - 1));
endmodule
`default_nettype wire

// ### swr_top.sv
// supply watchdog reset sequencer top
// assumes supply_ok_i from an analog comparator and kick/select/disable pins, all asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "swr_params.svh"
package swr_pkg;
   typedef enum logic [2:0] {
      SWR_HOLD = 3'b001,
      SWR_REL1 = 3'b010,
      SWR_RUN  = 3'b100
   } swr_state_e;
endpackage

module swr_top #(
   parameter int TICK_CYC = `SWR_TICK_CYC,
   parameter int T1_TICKS = `SWR_T1_TICKS,
   parameter int T2_TICKS = `SWR_T2_TICKS,
   parameter int WD0_TICKS = `SWR_WD0_TICKS,
   parameter int WD1_TICKS = `SWR_WD1_TICKS,
   parameter int WD2_TICKS = `SWR_WD2_TICKS,
   parameter int WD3_TICKS = `SWR_WD3_TICKS
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic supply_ok_i,
   input wire logic watchdog_kick_input_i,
   input wire logic watchdog_disable_i,
   input wire logic timeout_select_lsb_i,
   input wire logic timeout_select_msb_i,
   output logic primary_reset_n_o,
   output logic secondary_reset_n_o
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [`SWR_PIN_N-1:0] sync1_reg;
   logic [`SWR_PIN_N-1:0] sync2_reg;
   logic kick_d_reg;
   logic [`SWR_PIN_N-1:0] pins;
   assign pins = {supply_ok_i, watchdog_kick_input_i, watchdog_disable_i,
                  timeout_select_msb_i, timeout_select_lsb_i};

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         kick_d_reg <= 1'b0;
      end else if (ce_i) begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         kick_d_reg <= sync2_reg[`SWR_PIN_KICK];
      end
   end

   logic sup_ok;
   logic kick_edge;
   logic wd_off;
   logic [1:0] sel;
   assign sup_ok = sync2_reg[`SWR_PIN_SUP];
   assign kick_edge = sync2_reg[`SWR_PIN_KICK] ^ kick_d_reg;
   assign wd_off = sync2_reg[`SWR_PIN_DIS];
   assign sel = sync2_reg[`SWR_PIN_SEL_HI:`SWR_PIN_SEL_LO];

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   logic tick;
   swr_tick #(
      .TICK_CYC(TICK_CYC)
   ) u_tick (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .tick_o(tick)
   );

   // ------------------------------------------------------------
   // watchdog period select
   // ------------------------------------------------------------
   logic [`SWR_CNT_W-1:0] wd_limit;
   always_comb begin
      case (sel)
         2'b00: wd_limit = `SWR_CNT_W'(WD0_TICKS);
         2'b01: wd_limit = `SWR_CNT_W'(WD1_TICKS);
         2'b10: wd_limit = `SWR_CNT_W'(WD2_TICKS);
         default: wd_limit = `SWR_CNT_W'(WD3_TICKS);
      endcase
   end

   // ------------------------------------------------------------
   // reset sequencer
   // ------------------------------------------------------------
   swr_pkg::swr_state_e state_reg;
   swr_pkg::swr_state_e state_next;
   logic [`SWR_CNT_W-1:0] cnt_reg;
   logic [`SWR_CNT_W-1:0] cnt_next;
   logic p_n_reg;
   logic p_n_next;
   logic s_n_reg;
   logic s_n_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      p_n_next = p_n_reg;
      s_n_next = s_n_reg;
      if (!sup_ok) begin
         // supply low forces both outputs low together
         state_next = swr_pkg::SWR_HOLD;
         cnt_next = '0;
         p_n_next = 1'b0;
         s_n_next = 1'b0;
      end else begin
         case (state_reg)
            swr_pkg::SWR_HOLD: begin
               if (tick) begin
                  cnt_next = cnt_reg + 1'b1;
               end
               if (tick && cnt_reg == `SWR_CNT_W'(T1_TICKS - 1)) begin
                  // primary release restarts the watchdog
                  state_next = swr_pkg::SWR_REL1;
                  cnt_next = '0;
                  p_n_next = 1'b1;
               end
            end
            swr_pkg::SWR_REL1: begin
               // watchdog already running while secondary still held
               if (kick_edge || wd_off) begin
                  cnt_next = '0;
               end else if (tick) begin
                  cnt_next = cnt_reg + 1'b1;
               end
               if (tick && cnt_reg == `SWR_CNT_W'(T2_TICKS - 1)) begin
                  s_n_next = 1'b1;
               end
               if (!wd_off && !kick_edge && tick && cnt_reg == wd_limit - 1'b1) begin
                  state_next = swr_pkg::SWR_HOLD;
                  cnt_next = '0;
                  p_n_next = 1'b0;
                  s_n_next = 1'b0;
               end else if (s_n_reg || (tick && cnt_reg == `SWR_CNT_W'(T2_TICKS - 1))) begin
                  state_next = (s_n_reg) ? swr_pkg::SWR_RUN : swr_pkg::SWR_REL1;
               end
            end
            swr_pkg::SWR_RUN: begin
               if (kick_edge || wd_off) begin
                  cnt_next = '0;
               end else if (tick) begin
                  cnt_next = cnt_reg + 1'b1;
               end
               if (!wd_off && !kick_edge && tick && cnt_reg >= wd_limit - 1'b1) begin
                  state_next = swr_pkg::SWR_HOLD;
                  cnt_next = '0;
                  p_n_next = 1'b0;
                  s_n_next = 1'b0;
               end
            end
            default: begin
               state_next = swr_pkg::SWR_HOLD;
               cnt_next = '0;
               p_n_next = 1'b0;
               s_n_next = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // secondary release timer
   // ------------------------------------------------------------
   // secondary timing in REL1 shares the watchdog counter only until the first kick;
   // a separate counter keeps the 10 ms exact regardless of kicks
   logic [`SWR_CNT_W-1:0] sec_cnt_reg;
   logic [`SWR_CNT_W-1:0] sec_cnt_next;
   logic sec_done;
   always_comb begin
      sec_cnt_next = sec_cnt_reg;
      if (state_reg != swr_pkg::SWR_REL1 || !sup_ok) begin
         sec_cnt_next = '0;
      end else if (tick) begin
         sec_cnt_next = sec_cnt_reg + 1'b1;
      end
   end
   assign sec_done = tick && sec_cnt_reg == `SWR_CNT_W'(T2_TICKS - 1);

   logic s_n_fix;
   swr_pkg::swr_state_e state_fix;
   always_comb begin
      s_n_fix = s_n_next;
      state_fix = state_next;
      if (sup_ok && state_reg == swr_pkg::SWR_REL1 && state_next == swr_pkg::SWR_REL1) begin
         s_n_fix = s_n_reg | sec_done;
         state_fix = (s_n_reg | sec_done) ? swr_pkg::SWR_RUN : swr_pkg::SWR_REL1;
      end else if (sup_ok && state_reg == swr_pkg::SWR_REL1 && state_next == swr_pkg::SWR_RUN) begin
         s_n_fix = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= swr_pkg::SWR_HOLD;
         cnt_reg <= '0;
         sec_cnt_reg <= '0;
         p_n_reg <= 1'b0;
         s_n_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_fix;
         cnt_reg <= cnt_next;
         sec_cnt_reg <= sec_cnt_next;
         p_n_reg <= p_n_next;
         s_n_reg <= s_n_fix;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign primary_reset_n_o = p_n_reg;
   assign secondary_reset_n_o = s_n_reg;
endmodule
`default_nettype wire

// ### swr_chk_assertions.sv
// assertions on the sequencer top ports
// assumes bench counts: tick 4 cycles, hold 20 ticks, extra 4, periods 15 to 50 ticks
`timescale 1ns/1ns
`default_nettype none
module swr_chk (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic supply_ok_i,
   input wire logic watchdog_kick_input_i,
   input wire logic watchdog_disable_i,
   input wire logic primary_reset_n_o,
   input wire logic secondary_reset_n_o
);
   logic [7:0] quiet_reg;
   logic [7:0] quiet_next;
   logic kick_reg;
   // cycles of running watchdog with a still kick pin
   always_comb begin
      quiet_next = quiet_reg + 8'h01;
      if (!primary_reset_n_o || watchdog_disable_i || kick_reg != watchdog_kick_input_i) quiet_next = 8'h00;
      else if (quiet_reg == 8'hff) quiet_next = quiet_reg;
   end
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         quiet_reg <= 8'h00;
         kick_reg <= 1'b0;
      end else begin
         quiet_reg <= quiet_next;
         kick_reg <= watchdog_kick_input_i;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   supply_low_a: assert property ((!supply_ok_i) [*4] |-> !primary_reset_n_o && !secondary_reset_n_o)
      else $error("reset output high with supply low");
   fall_together_a: assert property ($fell(primary_reset_n_o) |-> !secondary_reset_n_o)
      else $error("primary fell alone");
   release_order_a: assert property (secondary_reset_n_o |-> primary_reset_n_o)
      else $error("secondary released first");
   secondary_gap_a: assert property ($rose(secondary_reset_n_o) |->
      $past(primary_reset_n_o, 16) && !$past(primary_reset_n_o, 17))
      else $error("secondary released off its time");
   power_hold_a: assert property ($rose(primary_reset_n_o) |-> $past(supply_ok_i, 78))
      else $error("primary released too soon");
   quiet_bound_a: assert property (quiet_reg < 8'hcb)
      else $error("watchdog never fired");
   fall_cause_a: assert property ($fell(primary_reset_n_o) |->
      $past(quiet_reg) > 8'h38 || !$past(supply_ok_i, 3) || !$past(supply_ok_i, 4))
      else $error("reset without cause");
   ce_freeze_a: assert property (!ce_i |=> $stable(primary_reset_n_o) && $stable(secondary_reset_n_o))
      else $error("outputs moved while frozen");
endmodule
bind swr_top swr_chk swr_chk_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .supply_ok_i(supply_ok_i),
   .watchdog_kick_input_i(watchdog_kick_input_i), .watchdog_disable_i(watchdog_disable_i),
   .primary_reset_n_o(primary_reset_n_o), .secondary_reset_n_o(secondary_reset_n_o));
`default_nettype wire

// ### swr_cpu.sv
// processor model toggling the kick line
// assumes the bench clock; kicks only while en_i is high
`timescale 1ns/1ns
`default_nettype none
module swr_cpu (
   input wire logic mclk_i,
   input wire logic en_i,
   output logic kick_o
);
   int cnt = 0;
   logic kick_reg = 1'b0;
   assign kick_o = kick_reg;
   // toggle every 6 cycles, inside the shortest period
   always @(negedge mclk_i) begin
      cnt = (cnt == 5) ? 0 : cnt + 1;
      if (en_i && cnt == 0) kick_reg <= !kick_reg;
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the reset sequencer
// assumes swr_top, swr_cpu and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "swr_params.svh"
module tb_top;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ce_i = 1'b1;
   logic supply_ok_i = 1'b1;
   logic dis = 1'b0;
   logic cpu_en = 1'b1;
   logic [1:0] sel = 2'h0;
   logic kick;
   logic pri;
   logic sec;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   // periods in ticks; the two short ones stay at their built-in defaults
   localparam int WD[4] = '{`SWR_WD0_TICKS, `SWR_WD1_TICKS, 40, 50};
   always #5 mclk_i = !mclk_i;
   swr_top #(.TICK_CYC(4), .T1_TICKS(20), .T2_TICKS(4), .WD2_TICKS(WD[2]),
      .WD3_TICKS(WD[3])) swr_top_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .supply_ok_i(supply_ok_i),
      .watchdog_kick_input_i(kick), .watchdog_disable_i(dis), .timeout_select_lsb_i(sel[0]),
      .timeout_select_msb_i(sel[1]), .primary_reset_n_o(pri), .secondary_reset_n_o(sec));
   swr_cpu swr_cpu_i (.mclk_i(mclk_i), .en_i(cpu_en), .kick_o(kick));
   task automatic tally_and_finish();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_rng(input string name, input int lo, input int hi, input int seen);
      n_compared++;
      if (seen < lo || seen > hi) begin
         n_fail++;
         $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, seen);
      end
   endtask
   task automatic chk_out(input string name, input logic [1:0] exp);
      n_compared++;
      if ({pri, sec} !== exp) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", name, exp, {pri, sec});
      end
   endtask
   // cycles until the chosen output shows val, bounded
   task automatic wait_for(input bit on_sec, input logic val, output int n);
      n = 0;
      while (((on_sec ? sec : pri) !== val) && n < 600) begin
         @(negedge mclk_i);
         n++;
      end
   endtask
   task automatic t_power_on();
      int n;
      chk_out("outputs before release", 2'b00);
      wait_for(1'b0, 1'b1, n);
      chk_rng("primary hold", 76, 88, n);
      wait_for(1'b1, 1'b1, n);
      chk_rng("secondary extra hold", 12, 20, n);
   endtask
   task automatic t_kick_hold();
      repeat (300) @(negedge mclk_i);
      chk_out("outputs while kicked", 2'b11);
      cpu_en = 1'b0;
      dis = 1'b1;
      repeat (300) @(negedge mclk_i);
      chk_out("outputs while disabled", 2'b11);
      ce_i = 1'b0;
      dis = 1'b0;
      repeat (100) @(negedge mclk_i);
      chk_out("outputs while frozen", 2'b11);
      ce_i = 1'b1;
      cpu_en = 1'b1;
   endtask
   task automatic t_supply_fail();
      supply_ok_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      chk_out("outputs on supply fail", 2'b00);
      repeat (150) @(negedge mclk_i);
      chk_out("outputs while supply low", 2'b00);
      supply_ok_i = 1'b1;
      t_power_on();
   endtask
   task automatic t_watchdog();
      int n;
      for (int s = 0; s < 4; s++) begin
         sel = s[1:0];
         cpu_en = 1'b0;
         wait_for(1'b0, 1'b0, n);
         wait_for(1'b0, 1'b1, n);
         chk_rng("primary hold after timeout", 76, 84, n);
         wait_for(1'b0, 1'b0, n);
         chk_rng("watchdog period", WD[s] * 4 - 4, WD[s] * 4 + 4, n);
         chk_out("outputs on timeout", 2'b00);
         cpu_en = 1'b1;
         wait_for(1'b1, 1'b1, n);
      end
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 8000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(negedge mclk_i);
      resetn_i = 1'b1;
      t_power_on();
      t_kick_hold();
      t_supply_fail();
      t_watchdog();
      tally_and_finish();
   end
endmodule
`default_nettype wire
